// ---- cta_control.sv ----
// Top of the counter array control: 16-bit counter, flags and two registers.
// Assumes a byte-wide special-function port and module event pulses on core_clk.
`timescale 1ns/1ps
module cta_control import cta_pkg::*; (
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Special-function register port
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_write,
	output logic [7:0] sfr_rdata,
	// Count sources
	input wire logic timer_zero_wrap,
	input wire logic external_event_input,
	input wire logic ext_osc_by_eight,
	input wire logic slow_osc_by_eight,
	// Core state and capture/compare modules
	input wire logic cpu_idle,
	input wire logic [2:0] module_event_set,
	input wire logic [2:0] module_irq_enable,
	// Counter and interrupt
	output logic [15:0] counter_value,
	output logic counter_wrap,
	output logic counter_array_irq
);
	typedef struct packed {
		logic [15:0] count;
		logic counter_overflow_flag;
		logic counter_run;
		logic [2:0] module_event_flag;
		logic idle_suspend;
		logic [2:0] timebase_select;
		logic overflow_irq_enable;
		logic wrap;
		logic irq;
		logic [7:0] rdata;
	} cta_state_t;

	cta_state_t st;
	cta_state_t next_st;
	logic suspended;
	logic count_en;
	logic wrap_now;
	logic ctl_wr;
	logic mode_wr;

	cta_tick_if tb_link ();

	assign suspended = st.idle_suspend & cpu_idle;
	assign tb_link.select = st.timebase_select;
	assign tb_link.hold = ~st.counter_run | suspended;

	cta_timebase u_timebase (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.timer_zero_wrap(timer_zero_wrap),
		.external_event_input(external_event_input),
		.ext_osc_by_eight(ext_osc_by_eight),
		.slow_osc_by_eight(slow_osc_by_eight),
		.tb(tb_link.gen)
	);

	assign counter_value = st.count;
	assign counter_wrap = st.wrap;
	assign counter_array_irq = st.irq;
	assign sfr_rdata = st.rdata;

	always_comb begin
		next_st = st;
		ctl_wr = sfr_write && (sfr_addr == CTA_CTRL_ADDR);
		mode_wr = sfr_write && (sfr_addr == CTA_MODE_ADDR);
		// Tick is rechecked here: it lags the hold by one cycle
		count_en = st.counter_run & ~suspended & tb_link.tick;
		wrap_now = count_en && (st.count == CTA_CNT_MAX);
		if (count_en) begin
			next_st.count = st.count + CTA_CNT_STEP;
		end
		next_st.wrap = wrap_now;
		if (ctl_wr) begin
			// Writing one sets a flag just as hardware would
			next_st.counter_overflow_flag =
				sfr_wdata[CTA_CTL_OVF_BIT];
			next_st.counter_run = sfr_wdata[CTA_CTL_RUN_BIT];
			next_st.module_event_flag =
				sfr_wdata[CTA_CTL_MOD_MSB:0];
		end
		// Hardware set comes last so it wins over a same-cycle clear
		if (wrap_now) begin
			next_st.counter_overflow_flag = 1'b1;
		end
		next_st.module_event_flag =
			next_st.module_event_flag | module_event_set;
		if (mode_wr) begin
			next_st.idle_suspend = sfr_wdata[CTA_MODE_IDLE_BIT];
			next_st.timebase_select =
				sfr_wdata[CTA_MODE_SEL_MSB:CTA_MODE_SEL_LSB];
			next_st.overflow_irq_enable =
				sfr_wdata[CTA_MODE_IEN_BIT];
		end
		next_st.irq = (next_st.counter_overflow_flag
			& next_st.overflow_irq_enable)
			| (|(next_st.module_event_flag & module_irq_enable));
		// Reserved fields read zero; unmapped addresses read zero
		case (sfr_addr)
			CTA_CTRL_ADDR: next_st.rdata = {st.counter_overflow_flag,
				st.counter_run, CTA_RSVD_READ, st.module_event_flag};
			CTA_MODE_ADDR: next_st.rdata = {st.idle_suspend,
				CTA_RSVD_READ, st.timebase_select, st.overflow_irq_enable};
			default: next_st.rdata = '0;
		endcase
	end

	// All fields reset to zero, select lands on the divide-by-12 code
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	ovf_flag_set_a: assert property (
		st.counter_run && !suspended && tb_link.tick
		&& st.count == CTA_CNT_MAX
		|=> st.counter_overflow_flag && st.count == CTA_CNT_ZERO && st.wrap
	) else $error("wrap did not set overflow flag");

	overflow_irq_a: assert property (
		st.counter_overflow_flag && st.overflow_irq_enable
		|-> counter_array_irq
	) else $error("overflow request missing");

	ovf_sticky_a: assert property (
		st.counter_overflow_flag && !ctl_wr |=> st.counter_overflow_flag
	) else $error("overflow flag cleared by hardware");

	ovf_clear_a: assert property (
		ctl_wr && !sfr_wdata[CTA_CTL_OVF_BIT] && !wrap_now
		|=> !st.counter_overflow_flag
	) else $error("software clear of overflow flag lost");

	run_gate_a: assert property (
		!st.counter_run |=> $stable(st.count)
	) else $error("counter moved while stopped");

	idle_hold_a: assert property (
		st.idle_suspend && cpu_idle |=> $stable(st.count)
	) else $error("counter moved while suspended");

	count_step_a: assert property (
		count_en |=> st.count == $past(st.count) + CTA_CNT_STEP
	) else $error("counter did not step by one");

	no_tick_hold_a: assert property (
		!tb_link.tick |=> $stable(st.count)
	) else $error("counter moved without a tick");

	ovf_mask_a: assert property (
		!next_st.overflow_irq_enable && next_st.module_event_flag == '0
		|=> !counter_array_irq
	) else $error("masked overflow raised a request");

	module_irq_a: assert property (
		|(st.module_event_flag & $past(module_irq_enable))
		|-> counter_array_irq
	) else $error("module request missing");

	module_sticky_a: assert property (
		!ctl_wr |=> (st.module_event_flag & $past(st.module_event_flag))
		== $past(st.module_event_flag)
	) else $error("module flag cleared by hardware");

	event_set_a: assert property (
		ctl_wr |=> st.module_event_flag ==
		($past(sfr_wdata[CTA_CTL_MOD_MSB:0]) | $past(module_event_set))
	) else $error("module flag write or set lost");

	sel_write_a: assert property (
		mode_wr |=> st.timebase_select ==
		$past(sfr_wdata[CTA_MODE_SEL_MSB:CTA_MODE_SEL_LSB])
	) else $error("select write not taken");

	wrap_pulse_a: assert property (
		st.wrap |-> st.count == CTA_CNT_ZERO && st.counter_overflow_flag
		&& $past(st.count) == CTA_CNT_MAX
	) else $error("wrap pulse without a wrap");

	ovf_write_one_a: assert property (
		ctl_wr && sfr_wdata[CTA_CTL_OVF_BIT] |=> st.counter_overflow_flag
	) else $error("overflow flag write of one lost");

	run_write_a: assert property (
		ctl_wr |=> st.counter_run == $past(sfr_wdata[CTA_CTL_RUN_BIT])
	) else $error("run bit write not taken");

	idle_write_a: assert property (
		mode_wr |=> st.idle_suspend
		== $past(sfr_wdata[CTA_MODE_IDLE_BIT])
	) else $error("idle bit write not taken");

	ien_write_a: assert property (
		mode_wr |=> st.overflow_irq_enable
		== $past(sfr_wdata[CTA_MODE_IEN_BIT])
	) else $error("overflow enable write not taken");

	irq_quiet_a: assert property (
		!(st.counter_overflow_flag && st.overflow_irq_enable)
		&& st.module_event_flag == '0 |-> !counter_array_irq
	) else $error("request raised with nothing pending");

	ctrl_read_a: assert property (
		$past(sfr_addr) == CTA_CTRL_ADDR |-> sfr_rdata ==
		{$past(st.counter_overflow_flag), $past(st.counter_run),
		CTA_RSVD_READ, $past(st.module_event_flag)}
	) else $error("control register read wrong");

	mode_read_a: assert property (
		$past(sfr_addr) == CTA_MODE_ADDR |-> sfr_rdata ==
		{$past(st.idle_suspend), CTA_RSVD_READ,
		$past(st.timebase_select), $past(st.overflow_irq_enable)}
	) else $error("mode register read wrong");
endmodule : cta_control

// ---- cta_pkg.sv ----
// Constants, field positions and types for the counter array control block.
// Assumes one system clock domain and a byte-wide special-function port.

package cta_pkg;
	localparam logic [7:0] CTA_MODE_ADDR = 8'hd9;
	localparam logic [7:0] CTA_CTRL_ADDR = 8'hd8;
	localparam int unsigned CTA_CTL_OVF_BIT = 7;
	localparam int unsigned CTA_CTL_RUN_BIT = 6;
	localparam int unsigned CTA_CTL_MOD_MSB = 2;
	localparam int unsigned CTA_MODE_IDLE_BIT = 7;
	localparam int unsigned CTA_MODE_SEL_MSB = 3;
	localparam int unsigned CTA_MODE_SEL_LSB = 1;
	localparam int unsigned CTA_MODE_IEN_BIT = 0;
	localparam int unsigned CTA_NUM_MODULES = 3;
	localparam logic [2:0] CTA_RSVD_READ = 3'h0;
	localparam logic [15:0] CTA_CNT_MAX = 16'hffff;
	localparam logic [15:0] CTA_CNT_ZERO = 16'h0000;
	localparam logic [15:0] CTA_CNT_STEP = 16'h0001;
	localparam logic [3:0] CTA_DIV12_LAST = 4'hb;
	localparam logic [3:0] CTA_DIV12_STEP = 4'h1;
	localparam logic [1:0] CTA_DIV4_LAST = 2'h3;
	localparam logic [1:0] CTA_DIV4_STEP = 2'h1;
	localparam int unsigned CTA_SRC_ECI = 0;
	localparam int unsigned CTA_SRC_EXT = 1;
	localparam int unsigned CTA_SRC_SLOW = 2;

	typedef enum logic [2:0] {
		TB_DIV12,
		TB_DIV4,
		TB_T0,
		TB_ECI,
		TB_SYSTEM_CLOCK,
		TB_EXTOSC,
		TB_SLOWOSC,
		TB_UNUSED
	} cta_timebase_t;
endpackage : cta_pkg

// ---- cta_tick_if.sv ----
// Timebase request and tick between the control top and the timebase module.
// Assumes both ends run on core_clk.
`timescale 1ns/1ps
interface cta_tick_if;
	logic [2:0] select;
	logic hold;
	logic tick;
	modport gen (input select, input hold, output tick);
	modport use_end (output select, output hold, input tick);
endinterface : cta_tick_if

// ---- cta_timebase.sv ----
// Prescalers, pin synchronisers and edge detectors for the count source.
// Assumes the oscillator inputs arrive divided by eight, off the core_clk domain.
`timescale 1ns/1ps
module cta_timebase import cta_pkg::*; (
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Count sources
	input wire logic timer_zero_wrap,
	input wire logic external_event_input,
	input wire logic ext_osc_by_eight,
	input wire logic slow_osc_by_eight,
	// Tick toward the control top
	cta_tick_if.gen tb
);
	typedef struct packed {
		logic [3:0] div12;
		logic [1:0] div4;
		logic [2:0] sync1;
		logic [2:0] sync2;
		logic [2:0] prev;
		logic tick;
	} cta_tb_state_t;

	cta_tb_state_t st;
	cta_tb_state_t next_st;
	logic src;

	assign tb.tick = st.tick;

	always_comb begin
		next_st = st;
		src = 1'b0;
		// Both stages per source, then a copy of the second; the edge test reads the second and its copy
		next_st.sync1 = {slow_osc_by_eight, ext_osc_by_eight,
			external_event_input};
		next_st.sync2 = st.sync1;
		next_st.prev = st.sync2;
		// Prescalers freeze when stopped so a restart keeps its phase
		if (!tb.hold) begin
			if (st.div12 == CTA_DIV12_LAST) begin
				next_st.div12 = '0;
			end else begin
				next_st.div12 = st.div12 + CTA_DIV12_STEP;
			end
			next_st.div4 = st.div4 + CTA_DIV4_STEP;
		end
		case (cta_timebase_t'(tb.select))
			TB_DIV12: src = (st.div12 == CTA_DIV12_LAST);
			TB_DIV4: src = (st.div4 == CTA_DIV4_LAST);
			TB_T0: src = timer_zero_wrap;
			TB_ECI: src = st.prev[CTA_SRC_ECI]
				& ~st.sync2[CTA_SRC_ECI];
			TB_SYSTEM_CLOCK: src = 1'b1;
			TB_EXTOSC: src = ~st.prev[CTA_SRC_EXT]
				& st.sync2[CTA_SRC_EXT];
			TB_SLOWOSC: src = ~st.prev[CTA_SRC_SLOW]
				& st.sync2[CTA_SRC_SLOW];
			default: src = 1'b0;
		endcase
		next_st.tick = src & ~tb.hold;
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	system_clock_tick_a: assert property (
		$past(tb.select) == TB_SYSTEM_CLOCK && !$past(tb.hold) |-> tb.tick
	) else $error("system_clock source gave no tick");

	div12_only_a: assert property (
		tb.tick && $past(tb.select) == TB_DIV12
		|-> $past(st.div12) == CTA_DIV12_LAST
	) else $error("div12 tick off its slot");

	eci_edge_a: assert property (
		tb.select == TB_ECI && !tb.hold && st.prev[CTA_SRC_ECI]
		&& !st.sync2[CTA_SRC_ECI] |=> tb.tick
	) else $error("event pin falling edge missed");

	ext_osc_edge_a: assert property (
		tb.select == TB_EXTOSC && !tb.hold && !st.prev[CTA_SRC_EXT]
		&& st.sync2[CTA_SRC_EXT] |=> tb.tick
	) else $error("external oscillator edge missed");

	slow_osc_edge_a: assert property (
		tb.tick && $past(tb.select) == TB_SLOWOSC
		|-> $past(st.sync2[CTA_SRC_SLOW]) && !$past(st.prev[CTA_SRC_SLOW])
	) else $error("slow oscillator tick without edge");
endmodule : cta_timebase

// ---- tb.sv ----
// Self-checking bench for the counter array control top.
// Assumes cta_pkg, cta_tick_if, cta_timebase and cta_control are compiled.
`timescale 1ns/1ps
module tb;
	import cta_pkg::*;
	// Clock and reset
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	// Register port
	logic [7:0] sfr_addr = 8'h00;
	logic [7:0] sfr_wdata = 8'h00;
	logic sfr_write = 1'b0;
	logic [7:0] sfr_rdata;
	// Sources, idle and module side
	logic t0w = 1'b0;
	logic evt = 1'b0;
	logic ext8 = 1'b0;
	logic slow8 = 1'b0;
	logic cpu_idle = 1'b0;
	logic [2:0] mset = 3'h0;
	logic [2:0] mien = 3'h0;
	// Outputs
	logic [15:0] counter_value;
	logic counter_wrap;
	logic irq;
	int n_mismatch = 0;
	int check_count = 0;

	cta_control i_dut (.core_clk(core_clk), .sys_rst(sys_rst),
		.sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_write(sfr_write),
		.sfr_rdata(sfr_rdata), .timer_zero_wrap(t0w),
		.external_event_input(evt), .ext_osc_by_eight(ext8),
		.slow_osc_by_eight(slow8), .cpu_idle(cpu_idle),
		.module_event_set(mset), .module_irq_enable(mien),
		.counter_value(counter_value), .counter_wrap(counter_wrap),
		.counter_array_irq(irq));

	always #50 core_clk = ~core_clk;

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask : cyc

	// Strobe spans one rising edge; an idle edge follows so that
	// back-to-back writes never touch the strobe twice in one step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_write = 1'b1;
		cyc(1);
		sfr_write = 1'b0;
		cyc(1);
	endtask : wr

	// Read data is registered, so look one cycle later
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		sfr_addr = a;
		cyc(1);
		chk({8'h00, sfr_rdata}, {8'h00, exp});
	endtask : rd

	task automatic span(input int n, input logic [15:0] exp);
		logic [15:0] c0;
		c0 = counter_value;
		cyc(n);
		chk(counter_value - c0, exp);
	endtask : span

	task automatic drive(input logic [2:0] sel, input logic v);
		case (sel)
			3'h2: t0w = v;
			3'h3: evt = v;
			3'h5: ext8 = v;
			default: slow8 = v;
		endcase
	endtask : drive

	task automatic t_reset_regs;
		rd(CTA_CTRL_ADDR, 8'h00);
		rd(CTA_MODE_ADDR, 8'h00);
		wr(8'h00, 8'hff);
		rd(8'h00, 8'h00);
		// Reserved bits always written as zero, module event flags here as one
		wr(CTA_CTRL_ADDR, 8'h07);
		rd(CTA_CTRL_ADDR, 8'h07);
		// Reset select is clock/12
		wr(CTA_CTRL_ADDR, 8'h40);
		cyc(15);
		span(24, 16'h0002);
		wr(CTA_MODE_ADDR, 8'h02);
		cyc(6);
		span(8, 16'h0002);
		wr(CTA_MODE_ADDR, 8'h08);
		cyc(3);
		span(10, 16'h000a);
		wr(CTA_CTRL_ADDR, 8'h00);
		cyc(3);
		span(10, 16'h0000);
		$display("test reset_regs done");
	endtask : t_reset_regs

	task automatic t_idle;
		cpu_idle = 1'b1;
		wr(CTA_MODE_ADDR, 8'h88);
		wr(CTA_CTRL_ADDR, 8'h40);
		cyc(3);
		span(10, 16'h0000);
		cpu_idle = 1'b0;
		cyc(3);
		span(10, 16'h000a);
		wr(CTA_MODE_ADDR, 8'h08);
		cpu_idle = 1'b1;
		cyc(3);
		span(10, 16'h000a);
		cpu_idle = 1'b0;
		wr(CTA_CTRL_ADDR, 8'h00);
		$display("test idle done");
	endtask : t_idle

	// Five source events, pin spacing kept at clock/8
	task automatic t_src(input logic [2:0] sel, input int hi);
		logic [15:0] c0;
		wr(CTA_MODE_ADDR, {4'h0, sel, 1'b0});
		wr(CTA_CTRL_ADDR, 8'h40);
		cyc(6);
		c0 = counter_value;
		for (int i = 0; i < 5; i++) begin
			drive(sel, 1'b1);
			cyc(hi);
			drive(sel, 1'b0);
			cyc(8 - hi);
		end
		cyc(6);
		chk(counter_value - c0, 16'h0005);
		wr(CTA_CTRL_ADDR, 8'h00);
		$display("test source %0d done", sel);
	endtask : t_src

	task automatic t_overflow;
		int i;
		wr(CTA_MODE_ADDR, 8'h09);
		wr(CTA_CTRL_ADDR, 8'h40);
		i = 0;
		while (counter_value !== 16'hffff && i < 70000) begin
			cyc(1);
			i++;
		end
		if (i >= 70000) begin
			n_mismatch++;
			$display("mismatch at %0t got %h exp %h", $time, i, 16'hffff);
			tally_and_finish();
		end
		cyc(1);
		chk(counter_value, 16'h0000);
		chk({15'h0, counter_wrap}, 16'h0001);
		cyc(1);
		chk({15'h0, irq}, 16'h0001);
		// Writing one keeps the flag while stopping the count
		wr(CTA_CTRL_ADDR, 8'h80);
		cyc(20);
		rd(CTA_CTRL_ADDR, 8'h80);
		wr(CTA_MODE_ADDR, 8'h08);
		cyc(2);
		chk({15'h0, irq}, 16'h0000);
		wr(CTA_CTRL_ADDR, 8'h00);
		rd(CTA_CTRL_ADDR, 8'h00);
		$display("test overflow done");
	endtask : t_overflow

	task automatic t_flags;
		mien = 3'b010;
		mset = 3'b010;
		cyc(1);
		mset = 3'b001;
		cyc(1);
		mset = 3'b000;
		chk({15'h0, irq}, 16'h0001);
		cyc(10);
		rd(CTA_CTRL_ADDR, 8'h03);
		wr(CTA_CTRL_ADDR, 8'h00);
		cyc(2);
		chk({15'h0, irq}, 16'h0000);
		mien = 3'b100;
		wr(CTA_CTRL_ADDR, 8'h04);
		cyc(2);
		chk({15'h0, irq}, 16'h0001);
		wr(CTA_CTRL_ADDR, 8'h00);
		mien = 3'b000;
		$display("test flags done");
	endtask : t_flags

	initial begin
		cyc(5);
		sys_rst = 1'b0;
		cyc(1);
		t_reset_regs();
		t_idle();
		t_src(3'h2, 1);
		t_src(3'h3, 4);
		t_src(3'h5, 4);
		t_src(3'h6, 4);
		t_flags();
		t_overflow();
		tally_and_finish();
	end
endmodule : tb
